// ===== include/dfp_pkg.sv
/*
 * Constants for the driver fault and protection control bank: register
 * offsets, field positions, reset values and timing counts.
 * Assumes a 125 MHz core clock; every time below is turned into cycles here.
 */
`default_nettype none

package dfp_pkg;

	// register offsets on the configuration port
	localparam logic [7:0] FAULT_RETRY_WAKE_CONTROL_OFS   = 8'h05;
	localparam logic [7:0] PROTECTION_DISABLE_CONTROL_OFS = 8'h06;

	// reset values
	localparam logic [7:0] FAULT_RETRY_WAKE_CONTROL_RST   = 8'h43;
	localparam logic [7:0] PROTECTION_DISABLE_CONTROL_RST = 8'h00;

	// fault_retry_wake_control fields
	localparam int SOFT_RESET_TRIGGER_BIT = 7;
	localparam int FAULT_RETRY_ENABLE_BIT = 6;
	localparam int FAULT_OFF_TIME_LSB     = 4;
	localparam int BLANK_SEL_LSB          = 2;
	localparam int WAKE_DETECT_LSB        = 0;

	// protection_disable_control fields
	localparam int SURGE_GUARD_OFF_BIT         = 6;
	localparam int MONITOR_DEGLITCH_OFF_BIT    = 4;
	localparam int IO_REGULATOR_OFF_BIT        = 3;
	localparam int OVERLOAD_CUTOFF_OFF_BIT     = 2;
	localparam int THERMAL_CUTOFF_OFF_BIT      = 1;
	localparam int UNDERVOLTAGE_CUTOFF_OFF_BIT = 0;
	// only these bits are writable; reserved bits 7 and 5 read zero
	localparam logic [7:0] PROTECTION_WRITE_MASK = 8'h5f;

	// wake detection source codes
	localparam logic [1:0] WAKE_NONE   = 2'h0;
	localparam logic [1:0] WAKE_LEVEL  = 2'h1;
	localparam logic [1:0] WAKE_RXTX   = 2'h2;
	localparam logic [1:0] WAKE_EITHER = 2'h3;

	// timing
	localparam int CLK_KHZ      = 125000;
	localparam int OFF_T0_MS    = 50;
	localparam int OFF_T1_MS    = 100;
	localparam int OFF_T2_MS    = 200;
	localparam int OFF_T3_MS    = 500;
	localparam int BLANK_T0_US  = 128;
	localparam int BLANK_T1_US  = 500;
	localparam int BLANK_T2_US  = 1000;
	localparam int BLANK_T3_US  = 5000;
	localparam int OFF_CYC0     = OFF_T0_MS * CLK_KHZ;
	localparam int OFF_CYC1     = OFF_T1_MS * CLK_KHZ;
	localparam int OFF_CYC2     = OFF_T2_MS * CLK_KHZ;
	localparam int OFF_CYC3     = OFF_T3_MS * CLK_KHZ;
	localparam int BLANK_CYC0   = (BLANK_T0_US * CLK_KHZ) / 1000;
	localparam int BLANK_CYC1   = (BLANK_T1_US * CLK_KHZ) / 1000;
	localparam int BLANK_CYC2   = (BLANK_T2_US * CLK_KHZ) / 1000;
	localparam int BLANK_CYC3   = (BLANK_T3_US * CLK_KHZ) / 1000;
	localparam int DEGLITCH_CYC = 16;
	localparam int TIMER_W      = 32;

	typedef enum logic [1:0] {
		DFP_ON       = 2'b00,
		DFP_OFF_TIME = 2'b01,
		DFP_OFF_HOLD = 2'b10
	} dfp_state_t;

endpackage

`default_nettype wire

// ===== rtl/dfp_ctrl.sv
/*
 * Driver fault and protection control: two configuration registers, the
 * driver fault state machine, current limit blanking, monitor deglitch and
 * wake source selection.
 * Assumes the one-wire front end delivers decoded byte accesses synchronous
 * to mclk, and analog monitor flags already synchronised to mclk.
 */
`default_nettype none

module dfp_ctrl #(
	parameter int OFF_CYC0   = dfp_pkg::OFF_CYC0,
	parameter int OFF_CYC1   = dfp_pkg::OFF_CYC1,
	parameter int OFF_CYC2   = dfp_pkg::OFF_CYC2,
	parameter int OFF_CYC3   = dfp_pkg::OFF_CYC3,
	parameter int BLANK_CYC0 = dfp_pkg::BLANK_CYC0,
	parameter int BLANK_CYC1 = dfp_pkg::BLANK_CYC1,
	parameter int BLANK_CYC2 = dfp_pkg::BLANK_CYC2,
	parameter int BLANK_CYC3 = dfp_pkg::BLANK_CYC3
) (
	input  wire logic       mclk,                 // core clock
	input  wire logic       resetn,               // async reset, active low
	input  wire logic       ce,                   // clock enable
	input  wire logic [7:0] reg_addr,             // register offset
	input  wire logic       reg_wr,               // write strobe
	input  wire logic       reg_rd,               // read strobe
	input  wire logic [7:0] reg_wdata,            // write data
	output logic      [7:0] reg_rdata,            // read data, one cycle after reg_rd
	input  wire logic       current_limit_raw,    // driver is in current limit
	input  wire logic       thermal_raw,          // over-temperature monitor
	input  wire logic       undervoltage_raw,     // supply monitor, low supply
	input  wire logic       temp_above_hyst,      // temperature above release level
	input  wire logic       overvoltage_level_condition, // wake source: line level
	input  wire logic       rxtx_mismatch,        // wake source: rx differs from tx
	output logic            driver_enable,        // line driver may drive
	output logic            current_limit_flag,   // current limit past blanking
	output logic            wake_detect,          // selected wake source active
	output logic            soft_reset_pulse,     // clears status and interrupt
	output logic            surge_guard_en,       // surge protection active
	output logic            io_regulator_en,      // 3.3 V regulator running
	output logic            thermal_mon,          // filtered thermal flag
	output logic            undervoltage_mon      // filtered supply flag
);

	localparam int TW = dfp_pkg::TIMER_W;

	function automatic logic [TW-1:0] pick4(input logic [1:0] sel, input int c0, input int c1,
		input int c2, input int c3);
		case (sel)
			2'h0:    pick4 = TW'(c0);
			2'h1:    pick4 = TW'(c1);
			2'h2:    pick4 = TW'(c2);
			default: pick4 = TW'(c3);
		endcase
	endfunction

	logic [7:0]          ctrl_q, ctrl_d, prot_q, prot_d, rdata_q, rdata_d;
	logic                soft_reset_trigger_q, soft_reset_trigger_d, soft_req;
	dfp_pkg::dfp_state_t state_q, state_d;
	logic [TW-1:0]       off_cnt_q, off_cnt_d, blank_cnt_q, blank_cnt_d;
	logic                cl_flag_q, cl_flag_d, wake_q, wake_d;
	logic [4:0]          dg_cnt_q, dg_cnt_d;
	logic                therm_f_q, therm_f_d, uv_f_q, uv_f_d;
	logic                fault_evt, retry_en, therm_in, uv_in;
	logic [TW-1:0]       cur_off_lim, cur_blank_lim;

	assign soft_req = ce && reg_wr && reg_addr == dfp_pkg::FAULT_RETRY_WAKE_CONTROL_OFS
		&& reg_wdata[dfp_pkg::SOFT_RESET_TRIGGER_BIT];
	assign retry_en      = ctrl_q[dfp_pkg::FAULT_RETRY_ENABLE_BIT];
	assign cur_off_lim   = pick4(ctrl_q[dfp_pkg::FAULT_OFF_TIME_LSB +: 2],
		OFF_CYC0, OFF_CYC1, OFF_CYC2, OFF_CYC3);
	assign cur_blank_lim = pick4(ctrl_q[dfp_pkg::BLANK_SEL_LSB +: 2],
		BLANK_CYC0, BLANK_CYC1, BLANK_CYC2, BLANK_CYC3);

	// registers
	always_comb
	begin
		ctrl_d  = ctrl_q;
		prot_d  = prot_q;
		rdata_d = rdata_q;
		soft_reset_trigger_d = ce ? 1'b0 : soft_reset_trigger_q; // frozen with the rest while ce is low
		if (soft_req)
		begin
			ctrl_d  = dfp_pkg::FAULT_RETRY_WAKE_CONTROL_RST;
			prot_d  = dfp_pkg::PROTECTION_DISABLE_CONTROL_RST;
			soft_reset_trigger_d = 1'b1;
		end
		else if (ce && reg_wr && reg_addr == dfp_pkg::FAULT_RETRY_WAKE_CONTROL_OFS)
			ctrl_d = {1'b0, reg_wdata[6:0]};
		else if (ce && reg_wr && reg_addr == dfp_pkg::PROTECTION_DISABLE_CONTROL_OFS)
			prot_d = reg_wdata & dfp_pkg::PROTECTION_WRITE_MASK;
		if (ce && reg_rd)
		begin
			if (reg_addr == dfp_pkg::FAULT_RETRY_WAKE_CONTROL_OFS)
				rdata_d = ctrl_q;
			else if (reg_addr == dfp_pkg::PROTECTION_DISABLE_CONTROL_OFS)
				rdata_d = prot_q;
			else
				rdata_d = 8'h00;
		end
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			ctrl_q  <= dfp_pkg::FAULT_RETRY_WAKE_CONTROL_RST;
			prot_q  <= dfp_pkg::PROTECTION_DISABLE_CONTROL_RST;
			rdata_q <= 8'h00;
			soft_reset_trigger_q <= 1'b0;
		end
		else
		begin
			ctrl_q  <= ctrl_d;
			prot_q  <= prot_d;
			rdata_q <= rdata_d;
			soft_reset_trigger_q <= soft_reset_trigger_d;
		end
	end

	// monitor deglitch: a change must hold for DEGLITCH_CYC cycles to pass
	always_comb
	begin
		therm_f_d = therm_f_q;
		uv_f_d    = uv_f_q;
		dg_cnt_d  = dg_cnt_q;
		if (ce)
		begin
			dg_cnt_d = dg_cnt_q + 5'h01;
			if (prot_q[dfp_pkg::MONITOR_DEGLITCH_OFF_BIT]
				|| dg_cnt_q == 5'(dfp_pkg::DEGLITCH_CYC - 1))
			begin
				therm_f_d = thermal_raw;
				uv_f_d    = undervoltage_raw;
				dg_cnt_d  = 5'h00;
			end
			else if (thermal_raw == therm_f_q && undervoltage_raw == uv_f_q)
				dg_cnt_d = 5'h00;
		end
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			therm_f_q <= 1'b0;
			uv_f_q    <= 1'b0;
			dg_cnt_q  <= 5'h00;
		end
		else
		begin
			therm_f_q <= therm_f_d;
			uv_f_q    <= uv_f_d;
			dg_cnt_q  <= dg_cnt_d;
		end
	end

	// current limit blanking and wake source
	always_comb
	begin
		blank_cnt_d = blank_cnt_q;
		cl_flag_d   = cl_flag_q;
		wake_d      = wake_q;
		if (ce)
		begin
			cl_flag_d = current_limit_raw && !soft_req && blank_cnt_q >= cur_blank_lim;
			if (!current_limit_raw || soft_req)
				blank_cnt_d = '0;
			else if (blank_cnt_q < cur_blank_lim)
				blank_cnt_d = blank_cnt_q + TW'(1);
			case (ctrl_q[dfp_pkg::WAKE_DETECT_LSB +: 2])
				dfp_pkg::WAKE_LEVEL:  wake_d = overvoltage_level_condition;
				dfp_pkg::WAKE_RXTX:   wake_d = rxtx_mismatch;
				dfp_pkg::WAKE_EITHER: wake_d = overvoltage_level_condition || rxtx_mismatch;
				default:              wake_d = 1'b0;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			blank_cnt_q <= '0;
			cl_flag_q   <= 1'b0;
			wake_q      <= 1'b0;
		end
		else
		begin
			blank_cnt_q <= blank_cnt_d;
			cl_flag_q   <= cl_flag_d;
			wake_q      <= wake_d;
		end
	end

	// fault state machine
	assign therm_in  = therm_f_q && !prot_q[dfp_pkg::THERMAL_CUTOFF_OFF_BIT];
	assign uv_in     = uv_f_q && !prot_q[dfp_pkg::UNDERVOLTAGE_CUTOFF_OFF_BIT];
	assign fault_evt = (cl_flag_q && !prot_q[dfp_pkg::OVERLOAD_CUTOFF_OFF_BIT])
		|| therm_in;

	always_comb
	begin
		state_d   = state_q;
		off_cnt_d = off_cnt_q;
		if (soft_req)
		begin
			state_d   = dfp_pkg::DFP_ON;
			off_cnt_d = '0;
		end
		else if (ce)
		begin
			case (state_q)
				dfp_pkg::DFP_ON:
					if (fault_evt)
						state_d = retry_en ? dfp_pkg::DFP_OFF_TIME : dfp_pkg::DFP_OFF_HOLD;
				dfp_pkg::DFP_OFF_TIME:
					if (off_cnt_q >= cur_off_lim - TW'(1))
					begin
						off_cnt_d = '0;
						state_d   = dfp_pkg::DFP_ON;
					end
					else
						off_cnt_d = off_cnt_q + TW'(1);
				dfp_pkg::DFP_OFF_HOLD:
					if (!temp_above_hyst)
						state_d = dfp_pkg::DFP_ON;
				default:
					state_d = dfp_pkg::DFP_ON;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_q   <= dfp_pkg::DFP_ON;
			off_cnt_q <= '0;
		end
		else
		begin
			state_q   <= state_d;
			off_cnt_q <= off_cnt_d;
		end
	end

	// undervoltage gates the driver directly; it is not a latched fault
	assign driver_enable      = state_q == dfp_pkg::DFP_ON && !uv_in;
	assign current_limit_flag = cl_flag_q;
	assign wake_detect        = wake_q;
	assign soft_reset_pulse   = soft_reset_trigger_q;
	assign reg_rdata          = rdata_q;
	assign surge_guard_en     = !prot_q[dfp_pkg::SURGE_GUARD_OFF_BIT];
	assign io_regulator_en    = !prot_q[dfp_pkg::IO_REGULATOR_OFF_BIT];
	assign thermal_mon        = therm_f_q;
	assign undervoltage_mon   = uv_f_q;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	property p_soft_reset_trigger_defaults;
		soft_req |=> ctrl_q == dfp_pkg::FAULT_RETRY_WAKE_CONTROL_RST
			&& prot_q == dfp_pkg::PROTECTION_DISABLE_CONTROL_RST;
	endproperty
	a_soft_reset_trigger_defaults: assert property (p_soft_reset_trigger_defaults) else $error("soft reset defaults");
	property p_soft_reset_trigger_clear;
		soft_req |=> soft_reset_pulse && state_q == dfp_pkg::DFP_ON
			##1 !soft_reset_pulse || $past(soft_req) || !$past(ce);
	endproperty
	a_soft_reset_trigger_clear: assert property (p_soft_reset_trigger_clear) else $error("soft reset clear");
	property p_retry_off;
		ce && !soft_req && state_q == dfp_pkg::DFP_ON && fault_evt && retry_en
			|=> state_q == dfp_pkg::DFP_OFF_TIME && !driver_enable;
	endproperty
	a_retry_off: assert property (p_retry_off) else $error("retry off missing");
	property p_hold;
		state_q == dfp_pkg::DFP_OFF_HOLD && temp_above_hyst && !soft_req
			|=> state_q == dfp_pkg::DFP_OFF_HOLD;
	endproperty
	a_hold: assert property (p_hold) else $error("hold released early");
	property p_off_time;
		ce && !soft_req && state_q == dfp_pkg::DFP_OFF_TIME && off_cnt_q < cur_off_lim - TW'(1)
			|=> state_q == dfp_pkg::DFP_OFF_TIME;
	endproperty
	a_off_time: assert property (p_off_time) else $error("off time cut short");
	property p_blank;
		$rose(current_limit_flag) |-> $past(blank_cnt_q) >= $past(cur_blank_lim)
			&& $past(current_limit_raw);
	endproperty
	a_blank: assert property (p_blank) else $error("blanking not honoured");
	property p_wake;
		ce && ctrl_q[1:0] == dfp_pkg::WAKE_NONE |=> !wake_detect;
	endproperty
	a_wake: assert property (p_wake) else $error("wake without source");
	property p_surge;
		ce && reg_wr && !soft_req && reg_addr == dfp_pkg::PROTECTION_DISABLE_CONTROL_OFS
			|=> surge_guard_en == !$past(reg_wdata[6]) && io_regulator_en == !$past(reg_wdata[3]);
	endproperty
	a_surge: assert property (p_surge) else $error("surge or regulator bit");
	property p_deglitch;
		ce && prot_q[dfp_pkg::MONITOR_DEGLITCH_OFF_BIT] |=> thermal_mon == $past(thermal_raw);
	endproperty
	a_deglitch: assert property (p_deglitch) else $error("deglitch not bypassed");
	property p_ocut;
		ce && !soft_req && state_q == dfp_pkg::DFP_ON && !therm_in && prot_q[2]
			|=> state_q == dfp_pkg::DFP_ON;
	endproperty
	a_ocut: assert property (p_ocut) else $error("overload cutoff not disabled");
	property p_rd_zero;
		ce && reg_rd && reg_addr == dfp_pkg::FAULT_RETRY_WAKE_CONTROL_OFS |=> !reg_rdata[7];
	endproperty
	a_rd_zero: assert property (p_rd_zero) else $error("soft reset bit reads one");

	c_retry:  cover property (state_q == dfp_pkg::DFP_OFF_TIME ##1 state_q == dfp_pkg::DFP_ON);
	c_hold:   cover property (state_q == dfp_pkg::DFP_OFF_HOLD ##1 state_q == dfp_pkg::DFP_ON);
	c_soft_reset_trigger:  cover property (soft_req);
	c_limit:  cover property ($rose(current_limit_flag));

endmodule

`default_nettype wire

// ===== sim/dfp_host_model.sv
/*
 * Host side of the configuration port: single byte writes and reads of the
 * protection bank, one strobe cycle each.
 * Assumes the bench owns mclk; every line changes on the falling edge only.
 */
`default_nettype none

module dfp_host_model (
	input  wire logic       mclk,      // core clock
	output logic      [7:0] reg_addr,  // register offset
	output logic            reg_wr,    // write strobe
	output logic            reg_rd,    // read strobe
	output logic      [7:0] reg_wdata, // write data
	input  wire logic [7:0] reg_rdata  // read data
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		reg_addr  = 8'h00;
		reg_wdata = 8'h00;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
	end

	// released lines show the inverse of the last value so nothing stale matches
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		reg_addr  = a;
		reg_wdata = d;
		reg_wr    = 1'b1;
		@(negedge mclk);
		reg_wr    = 1'b0;
		reg_addr  = ~a;
		reg_wdata = ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge mclk);
		reg_addr = a;
		reg_rd   = 1'b1;
		@(negedge mclk);
		reg_rd   = 1'b0;
		reg_addr = ~a;
		d        = reg_rdata;
	endtask

	// normal setup always asks for both wake sources
	task automatic cfg(input logic retry, input logic [1:0] off, input logic [1:0] blank);
		wr(8'h05, {1'b0, retry, off, blank, 2'h3});
	endtask

endmodule

`default_nettype wire

// ===== sim/driver_fault_protection_control_tb_top.sv
/*
 * Testbench for the fault and protection bank: register table, wake source,
 * blanking, retry and hold, cutoff disables, deglitch and soft reset.
 * Assumes shortened off and blanking counts handed in as parameters.
 */
`default_nettype none

`define CHK(nm, e, a) \
	begin \
		checked++; \
		if ((a) !== (e)) \
		begin \
			n_errors++; \
			$display("FAIL %s exp %h got %h", nm, e, a); \
		end \
	end

module driver_fault_protection_control_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int OC [4] = '{20, 40, 80, 200};
	localparam int BC [4] = '{4, 8, 16, 40};

	typedef struct {
		logic [7:0] a;
		logic [7:0] d;
		logic [7:0] r;
		logic       sg;
		logic       io;
	} dfp_row_t;

	logic       mclk, resetn, ce, reg_wr, reg_rd;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_v;
	logic       current_limit_raw, thermal_raw, undervoltage_raw, temp_above_hyst;
	logic       overvoltage_level_condition, rxtx_mismatch, driver_enable;
	logic       current_limit_flag, wake_detect, soft_reset_pulse, surge_guard_en;
	logic       io_regulator_en, thermal_mon, undervoltage_mon;
	int         n_errors, checked, n;
	dfp_row_t   rows [6];

	dfp_ctrl #(
		.OFF_CYC0(OC[0]), .OFF_CYC1(OC[1]), .OFF_CYC2(OC[2]), .OFF_CYC3(OC[3]),
		.BLANK_CYC0(BC[0]), .BLANK_CYC1(BC[1]), .BLANK_CYC2(BC[2]), .BLANK_CYC3(BC[3])
	) uut (
		.mclk, .resetn, .ce, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
		.current_limit_raw, .thermal_raw, .undervoltage_raw, .temp_above_hyst,
		.overvoltage_level_condition, .rxtx_mismatch, .driver_enable, .current_limit_flag,
		.wake_detect, .soft_reset_pulse, .surge_guard_en, .io_regulator_en,
		.thermal_mon, .undervoltage_mon
	);

	dfp_host_model host (
		.mclk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata
	);

	always #4 mclk = ~mclk;

	task automatic final_report;
		if (n_errors == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// counts falling edges until s reaches v; a spent bound ends the run
	task automatic wait_lvl(ref logic s, input logic v, input int lim, output int k);
		k = 0;
		while (s !== v)
		begin
			@(negedge mclk);
			k++;
			if (k > lim)
			begin
				n_errors++;
				final_report();
			end
		end
	endtask

	initial
	begin
		repeat (100000) @(posedge mclk);
		n_errors++;
		final_report();
	end

	initial
	begin
		{mclk, resetn, current_limit_raw, thermal_raw, undervoltage_raw} = '0;
		{temp_above_hyst, overvoltage_level_condition, rxtx_mismatch} = '0;
		ce = 1'b1;
		rows = '{'{8'h06, 8'hff, 8'h5f, 1'b0, 1'b0}, '{8'h06, 8'h40, 8'h40, 1'b0, 1'b1},
			'{8'h06, 8'h08, 8'h08, 1'b1, 1'b0}, '{8'h06, 8'h00, 8'h00, 1'b1, 1'b1},
			'{8'h05, 8'h7f, 8'h7f, 1'b1, 1'b1}, '{8'h10, 8'ha5, 8'h00, 1'b1, 1'b1}};
		repeat (10) @(negedge mclk);
		resetn = 1'b1;
		host.rd(8'h05, rd_v);
		`CHK("reset 05", 8'h43, rd_v)
		host.rd(8'h06, rd_v);
		`CHK("reset 06", 8'h00, rd_v)
		foreach (rows[i])
		begin
			host.wr(rows[i].a, rows[i].d);
			host.rd(rows[i].a, rd_v);
			`CHK("rdata", rows[i].r, rd_v)
			`CHK("surge_guard_en", rows[i].sg, surge_guard_en)
			`CHK("io_regulator_en", rows[i].io, io_regulator_en)
		end
		for (int c = 0; c < 4; c++)
		begin
			host.wr(8'h05, {6'h10, c[1:0]});
			for (int s = 0; s < 4; s++)
			begin
				{rxtx_mismatch, overvoltage_level_condition} = s[1:0];
				repeat (2) @(negedge mclk);
				`CHK("wake_detect", (c[0] & s[0]) | (c[1] & s[1]), wake_detect)
			end
		end
		{rxtx_mismatch, overvoltage_level_condition} = 2'h0;
		host.wr(8'h06, 8'h04);
		for (int b = 0; b < 4; b++)
		begin
			host.cfg(1'b1, 2'h0, b[1:0]);
			current_limit_raw = 1'b1;
			wait_lvl(current_limit_flag, 1'b1, 100, n);
			`CHK("blank cycles", BC[b] + 1, n)
			`CHK("driver kept on", 1'b1, driver_enable)
			current_limit_raw = 1'b0;
			wait_lvl(current_limit_flag, 1'b0, 4, n);
		end
		host.wr(8'h06, 8'h00);
		for (int o = 0; o < 4; o++)
		begin
			host.cfg(1'b1, o[1:0], 2'h0);
			current_limit_raw = 1'b1;
			wait_lvl(driver_enable, 1'b0, 20, n);
			`CHK("off delay", BC[0] + 2, n)
			current_limit_raw = 1'b0;
			wait_lvl(driver_enable, 1'b1, 300, n);
			`CHK("off cycles", OC[o], n)
		end
		host.wr(8'h06, 8'h10);
		host.cfg(1'b0, 2'h0, 2'h0);
		temp_above_hyst = 1'b1;
		thermal_raw = 1'b1;
		wait_lvl(driver_enable, 1'b0, 20, n);
		thermal_raw = 1'b0;
		repeat (300) @(negedge mclk);
		`CHK("held off", 1'b0, driver_enable)
		temp_above_hyst = 1'b0;
		wait_lvl(driver_enable, 1'b1, 3, n);
		host.wr(8'h06, 8'h12);
		thermal_raw = 1'b1;
		repeat (5) @(negedge mclk);
		`CHK("thermal ignored", 1'b1, driver_enable)
		`CHK("thermal_mon", 1'b1, thermal_mon)
		thermal_raw = 1'b0;
		host.wr(8'h06, 8'h00);
		undervoltage_raw = 1'b1;
		repeat (8) @(negedge mclk);
		`CHK("deglitch holds", 1'b0, undervoltage_mon)
		wait_lvl(undervoltage_mon, 1'b1, 20, n);
		`CHK("uv shutdown", 1'b0, driver_enable)
		host.wr(8'h06, 8'h01);
		@(negedge mclk);
		`CHK("uv ignored", 1'b1, driver_enable)
		undervoltage_raw = 1'b0;
		ce = 1'b0;
		host.wr(8'h06, 8'h40);
		ce = 1'b1;
		host.rd(8'h06, rd_v);
		`CHK("ce low write", 8'h01, rd_v)
		host.wr(8'h06, 8'h5f);
		current_limit_raw = 1'b1;
		wait_lvl(current_limit_flag, 1'b1, 20, n);
		host.wr(8'h05, 8'h80);
		`CHK("soft_reset_pulse", 1'b1, soft_reset_pulse)
		`CHK("status cleared", 1'b0, current_limit_flag)
		current_limit_raw = 1'b0;
		host.rd(8'h05, rd_v);
		`CHK("soft reset 05", 8'h43, rd_v)
		host.rd(8'h06, rd_v);
		`CHK("soft reset 06", 8'h00, rd_v)
		`CHK("surge after reset", 1'b1, surge_guard_en)
		final_report();
	end

endmodule

`default_nettype wire
